// ---- pkg/adcc_consts.svh ----
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_CTRL0     8'he0
`define ADCC_IDX_CTRL1     8'he1
`define ADCC_IDX_CTRL2     8'he2
`define ADCC_IDX_DLY       8'he3
`define ADCC_IDX_RES_LO    8'he4
`define ADCC_IDX_RES_HI    8'he5
`define ADCC_IDX_THR_LO    8'he6
`define ADCC_IDX_THR_HI    8'he7

// control 0 fields
`define ADCC_C0_DONE       7
`define ADCC_C0_START      6
`define ADCC_C0_RUN        5
// control 1 fields
`define ADCC_C1_DIV_HI     5
`define ADCC_C1_DIV_LO     4
`define ADCC_C1_EXTEN      1
// compare/acquisition control fields
`define ADCC_C2_BRAKE_EN   7
`define ADCC_C2_POL        6
`define ADCC_C2_GATE       5
`define ADCC_C2_CMPO       4
`define ADCC_C2_AQT_HI     3
`define ADCC_C2_AQT_LO     1
`define ADCC_C2_DLY8       0

`define ADCC_C0_RESET      8'h00
`define ADCC_C1_RESET      8'h00
`define ADCC_C2_RESET      8'h00
`define ADCC_DLY_RESET     8'h00
`define ADCC_THR_RESET     12'h000

// acquisition = step * field + base, in converter clocks
`define ADCC_ACQ_BASE      6'h06
`define ADCC_ACQ_SHIFT     2

`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2

`endif

// ---- pkg/adcc_pkg.sv ----
`default_nettype none
`include "adcc_consts.svh"

package adcc_pkg;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_ACQ  = 3'h2,
      SEQ_CONV = 3'h4
   } adcc_state_type;

   typedef struct packed {
      logic       en;
      logic [7:0] idx;
      logic [7:0] data;
   } adcc_regwr_type;

   typedef struct packed {
      logic        start;
      logic        done;
      logic [11:0] result;
   } adcc_core_type;

   function automatic logic adcc_mapped(input logic [7:0] idx);
      adcc_mapped = (idx >= `ADCC_IDX_CTRL0) && (idx <= `ADCC_IDX_THR_HI);
   endfunction : adcc_mapped

   // aligned, inside the window, and a known register
   function automatic logic adcc_hit(input logic [11:0] addr);
      adcc_hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && adcc_mapped(addr[9:2]);
   endfunction : adcc_hit

endpackage : adcc_pkg

`default_nettype wire

// ---- design/adcc_axil_slave.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcc_axil_slave (
   input  wire logic                    clock,    // system clock
   input  wire logic                    resetn,   // async reset, low
   input  wire logic [11:0]             awaddr,   // write address
   input  wire logic                    awvalid,  // write address valid
   output logic                         awready,  // write address ready
   input  wire logic [31:0]             wdata,    // write data
   input  wire logic [3:0]              wstrb,    // byte enables
   input  wire logic                    wvalid,   // write data valid
   output logic                         wready,   // write data ready
   output logic [1:0]                   bresp,    // write response
   output logic                         bvalid,   // write response valid
   input  wire logic                    bready,   // write response ready
   input  wire logic [11:0]             araddr,   // read address
   input  wire logic                    arvalid,  // read address valid
   output logic                         arready,  // read address ready
   output logic [31:0]                  rdata,    // read data
   output logic [1:0]                   rresp,    // read response
   output logic                         rvalid,   // read data valid
   input  wire logic                    rready,   // read data ready
   output adcc_pkg::adcc_regwr_type     regWr,    // register write strobe
   output logic [7:0]                   rdIdx,    // register read index
   input  wire logic [7:0]              rdData    // register read value
);
   import adcc_pkg::*;

   logic        awHeld_q;
   logic [11:0] awAddr_q;
   logic        wHeld_q;
   logic [7:0]  wData_q;
   logic        wLane_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        wrGo;

   assign awready = ~awHeld_q;
   assign wready  = ~wHeld_q;
   assign arready = ~rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign rdIdx   = araddr[9:2];

   assign wrGo       = awHeld_q & wHeld_q & ~bvalid_q;
   // only the low lane carries register bits
   assign regWr.en   = wrGo & wLane_q & adcc_hit(awAddr_q);
   assign regWr.idx  = awAddr_q[9:2];
   assign regWr.data = wData_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 12'h000;
      end else if (wrGo) begin
         awHeld_q <= 1'b0;
      end else if (awvalid && !awHeld_q) begin
         awHeld_q <= 1'b1;
         awAddr_q <= awaddr;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wHeld_q <= 1'b0;
         wData_q <= 8'h00;
         wLane_q <= 1'b0;
      end else if (wrGo) begin
         wHeld_q <= 1'b0;
      end else if (wvalid && !wHeld_q) begin
         wHeld_q <= 1'b1;
         wData_q <= wdata[7:0];
         wLane_q <= wstrb[0];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `ADCC_RESP_OKAY;
      end else if (wrGo) begin
         bvalid_q <= 1'b1;
         bresp_q  <= adcc_hit(awAddr_q) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `ADCC_RESP_OKAY;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= adcc_hit(araddr) ? {24'h00_0000, rdData} : 32'h0000_0000;
         rresp_q  <= adcc_hit(araddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule : adcc_axil_slave

`default_nettype wire

// ---- design/adcc_trig_delay.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcc_trig_delay #(
   parameter int DLY_W = 9                      // delay counter width
) (
   input  wire logic             clock,         // system clock
   input  wire logic             resetn,        // async reset, low
   input  wire logic             arm,           // accepted trigger, pulse
   input  wire logic             adcTick,       // converter clock enable
   input  wire logic [DLY_W-1:0] delayCount,    // programmed delay
   output logic                  pending,       // delay running
   output logic                  fire           // start conversion, pulse
);
   logic [DLY_W-1:0] cnt_q;
   logic             pending_q;

   assign pending = pending_q;
   // zero count fires at the first converter clock after the trigger
   assign fire    = pending_q & adcTick & (cnt_q == '0);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pending_q <= 1'b0;
         cnt_q     <= '0;
      end else if (!pending_q) begin
         if (arm) begin
            pending_q <= 1'b1;
            cnt_q     <= delayCount;
         end
      end else if (adcTick) begin
         if (cnt_q == '0) begin
            pending_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule : adcc_trig_delay

`default_nettype wire

// ---- design/adcc_top.sv ----
// Summary of operation
// - brake enable plus compare result raises brake
// - brake clears run bit; software resumes it
// - polarity 0: result at least threshold
// - polarity 1: result strictly below threshold
// - gating sets done only on matching result
// - gated done flag requests converter interrupt
// - gating repeats conversions until done flag
// - acquisition lasts four times field plus six
// - nine-bit delay split across two registers
// - delay equals count converter clock periods
// - delay only for external triggers, when enabled
// - control bit zero holds delay bit eight
// - done flag blocks starts; software clears
// - start bit starts, reads busy, self-clears
// - external triggers ignored while busy
// - converter clock is system clock divided
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module adcc_top (
   input  wire logic        clock,       // system clock, 125 MHz
   input  wire logic        resetn,      // async reset, low
   input  wire logic [11:0] awaddr,      // axi write address
   input  wire logic        awvalid,     // axi write address valid
   output logic             awready,     // axi write address ready
   input  wire logic [31:0] wdata,       // axi write data
   input  wire logic [3:0]  wstrb,       // axi byte enables
   input  wire logic        wvalid,      // axi write data valid
   output logic             wready,      // axi write data ready
   output logic [1:0]       bresp,       // axi write response
   output logic             bvalid,      // axi write response valid
   input  wire logic        bready,      // axi write response ready
   input  wire logic [11:0] araddr,      // axi read address
   input  wire logic        arvalid,     // axi read address valid
   output logic             arready,     // axi read address ready
   output logic [31:0]      rdata,       // axi read data
   output logic [1:0]       rresp,       // axi read response
   output logic             rvalid,      // axi read data valid
   input  wire logic        rready,      // axi read data ready
   input  wire logic        extTrigger,  // selected external trigger, async
   input  wire logic        coreDone,    // converter core finished, pulse
   input  wire logic [11:0] coreResult,  // converter core result
   output logic             coreStart,   // converter core start, pulse
   output logic             sampleEn,    // acquisition window
   output logic             pwmBrake,    // fault brake request to pwm
   output logic             pwm_run_bit,      // pwm run bit
   output logic             adcIrq       // converter interrupt request
);
   import adcc_pkg::*;

   adcc_regwr_type regWr;
   adcc_state_type state_q;
   logic [7:0]     rdIdx;
   logic [7:0]     rdData;
   logic           doneFlag_q;
   logic           run_q;
   logic [1:0]     div_q;
   logic           extEn_q;
   logic [7:0]     ctrl2_q;
   logic [7:0]     dlyLo_q;
   logic [11:0]    thr_q;
   logic [11:0]    result_q;
   logic           cmpo_q;
   logic [2:0]     divCnt_q;
   logic           adcTick;
   logic           extSync1_q;
   logic           extSync2_q;
   logic           extPrev_q;
   logic           trigEdge;
   logic           trigPending;
   logic           delayFire;
   logic           swStart;
   logic           startReq;
   logic           busy;
   logic           complete;
   logic           match;
   logic [5:0]     acqLoad;
   logic [5:0]     acqCnt_q;
   logic           wrCtrl0;

   function automatic logic cmpHit(input logic [11:0] res, input logic [11:0] thr,
                                   input logic pol);
      cmpHit = pol ? (res < thr) : (res >= thr);
   endfunction : cmpHit

   function automatic logic [2:0] divMask(input logic [1:0] div);
      case (div)
         2'h0:    divMask = 3'h0;
         2'h1:    divMask = 3'h1;
         2'h2:    divMask = 3'h3;
         default: divMask = 3'h7;
      endcase
   endfunction : divMask

   adcc_axil_slave u_bus (
      .clock   (clock),
      .resetn  (resetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .regWr   (regWr),
      .rdIdx   (rdIdx),
      .rdData  (rdData)
   );

   // converter clock as an enable; keeps one clock domain
   assign adcTick = ((divCnt_q & divMask(div_q)) == divMask(div_q));

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         divCnt_q <= 3'h0;
      end else begin
         divCnt_q <= divCnt_q + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
         extPrev_q  <= 1'b0;
      end else begin
         extSync1_q <= extTrigger;
         extSync2_q <= extSync1_q;
         extPrev_q  <= extSync2_q;
      end
   end

   assign trigEdge = extSync2_q & ~extPrev_q;
   assign busy     = (state_q != SEQ_IDLE);
   assign wrCtrl0  = regWr.en && (regWr.idx == `ADCC_IDX_CTRL0);
   assign swStart  = wrCtrl0 && regWr.data[`ADCC_C0_START];
   // a trigger is dropped, not queued, while a conversion runs
   assign startReq = (swStart | delayFire) & ~doneFlag_q & ~busy;
   assign acqLoad  = `ADCC_ACQ_BASE
                   + {1'b0, ctrl2_q[`ADCC_C2_AQT_HI:`ADCC_C2_AQT_LO], 2'h0};
   assign complete = (state_q == SEQ_CONV) & coreDone;
   assign match    = cmpHit(coreResult, thr_q, ctrl2_q[`ADCC_C2_POL]);

   adcc_trig_delay #(
      .DLY_W (9)
   ) u_delay (
      .clock      (clock),
      .resetn     (resetn),
      .arm        (trigEdge & extEn_q & ~busy),
      .adcTick    (adcTick),
      .delayCount ({ctrl2_q[`ADCC_C2_DLY8], dlyLo_q}),
      .pending    (trigPending),
      .fire       (delayFire)
   );

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q  <= SEQ_IDLE;
         acqCnt_q <= 6'h00;
      end else begin
         case (state_q)
            SEQ_IDLE: begin
               if (startReq) begin
                  state_q  <= SEQ_ACQ;
                  acqCnt_q <= acqLoad;
               end
            end
            SEQ_ACQ: begin
               if (adcTick) begin
                  if (acqCnt_q == 6'h01) begin
                     state_q <= SEQ_CONV;
                  end else begin
                     acqCnt_q <= acqCnt_q - 6'h01;
                  end
               end
            end
            SEQ_CONV: begin
               if (coreDone) begin
                  if (ctrl2_q[`ADCC_C2_GATE] && !match) begin
                     state_q  <= SEQ_ACQ;
                     acqCnt_q <= acqLoad;
                  end else begin
                     state_q <= SEQ_IDLE;
                  end
               end
            end
            default: state_q <= SEQ_IDLE;
         endcase
      end
   end

   assign sampleEn  = (state_q == SEQ_ACQ);
   assign coreStart = (state_q == SEQ_ACQ) & adcTick & (acqCnt_q == 6'h01);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         result_q <= 12'h000;
         cmpo_q   <= 1'b0;
      end else if (complete) begin
         result_q <= coreResult;
         cmpo_q   <= match;
      end
   end

   // a completion in the clearing cycle still leaves the flag set
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         doneFlag_q <= 1'b0;
      end else if (complete && (!ctrl2_q[`ADCC_C2_GATE] || match)) begin
         doneFlag_q <= 1'b1;
      end else if (wrCtrl0 && !regWr.data[`ADCC_C0_DONE]) begin
         doneFlag_q <= 1'b0;
      end
   end

   assign adcIrq = doneFlag_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_q <= 1'b0;
      end else if (complete && match && ctrl2_q[`ADCC_C2_BRAKE_EN]) begin
         run_q <= 1'b0;
      end else if (wrCtrl0) begin
         run_q <= regWr.data[`ADCC_C0_RUN];
      end
   end

   assign pwm_run_bit   = run_q;
   assign pwmBrake = ctrl2_q[`ADCC_C2_BRAKE_EN] & cmpo_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_q   <= 2'(`ADCC_C1_RESET >> `ADCC_C1_DIV_LO);
         extEn_q <= 1'b0;
         ctrl2_q <= `ADCC_C2_RESET;
         dlyLo_q <= `ADCC_DLY_RESET;
         thr_q   <= `ADCC_THR_RESET;
      end else if (regWr.en) begin
         case (regWr.idx)
            `ADCC_IDX_CTRL1: begin
               div_q   <= regWr.data[`ADCC_C1_DIV_HI:`ADCC_C1_DIV_LO];
               extEn_q <= regWr.data[`ADCC_C1_EXTEN];
            end
            // compare result bit is not writable
            `ADCC_IDX_CTRL2: ctrl2_q <= {regWr.data[7:5], 1'b0, regWr.data[3:0]};
            `ADCC_IDX_DLY:    dlyLo_q       <= regWr.data;
            `ADCC_IDX_THR_LO: thr_q[3:0]    <= regWr.data[3:0];
            `ADCC_IDX_THR_HI: thr_q[11:4]   <= regWr.data;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (rdIdx)
         `ADCC_IDX_CTRL0:  rdData = {doneFlag_q, busy, run_q, 5'h00};
         `ADCC_IDX_CTRL1:  rdData = {2'h0, div_q, 2'h0, extEn_q, 1'b0};
         `ADCC_IDX_CTRL2:  rdData = {ctrl2_q[7:5], cmpo_q, ctrl2_q[3:0]};
         `ADCC_IDX_DLY:    rdData = dlyLo_q;
         `ADCC_IDX_RES_LO: rdData = {4'h0, result_q[3:0]};
         `ADCC_IDX_RES_HI: rdData = result_q[11:4];
         `ADCC_IDX_THR_LO: rdData = {4'h0, thr_q[3:0]};
         `ADCC_IDX_THR_HI: rdData = thr_q[11:4];
         default:          rdData = 8'h00;
      endcase
   end

   // checking helpers
   logic [5:0] acqSeen_q;
   logic [5:0] acqLen_q;
   logic [9:0] dlySeen_q;
   logic [9:0] dlyLen_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         acqSeen_q <= 6'h00;
         acqLen_q  <= 6'h00;
      end else if ((state_q != SEQ_ACQ) || coreStart) begin
         acqSeen_q <= 6'h00;
         acqLen_q  <= acqLoad;
      end else if (adcTick) begin
         acqSeen_q <= acqSeen_q + 6'h01;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dlySeen_q <= 10'h000;
         dlyLen_q  <= 10'h000;
      end else if (!trigPending) begin
         dlySeen_q <= 10'h000;
         dlyLen_q  <= {1'b0, ctrl2_q[`ADCC_C2_DLY8], dlyLo_q} + 10'h001;
      end else if (adcTick) begin
         dlySeen_q <= dlySeen_q + 10'h001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   AST_BRAKE_RUN: assert property (
      complete && match && ctrl2_q[`ADCC_C2_BRAKE_EN] |=> pwmBrake && !pwm_run_bit)
      else $error("brake did not assert or run bit not cleared");
   AST_BRAKE_OFF: assert property (!ctrl2_q[`ADCC_C2_BRAKE_EN] |-> !pwmBrake)
      else $error("brake raised while disabled");
   AST_POL_GE: assert property (
      complete && !ctrl2_q[`ADCC_C2_POL] |=> cmpo_q == (result_q >= thr_q))
      else $error("compare result wrong for polarity 0");
   AST_POL_LT: assert property (
      complete && ctrl2_q[`ADCC_C2_POL] |=> cmpo_q == (result_q < thr_q))
      else $error("compare result wrong for polarity 1");
   AST_GATE_REPEAT: assert property (
      complete && ctrl2_q[`ADCC_C2_GATE] && !match |=> state_q == SEQ_ACQ && !$rose(doneFlag_q))
      else $error("gated mismatch did not repeat or set the flag");
   AST_ACQ_LEN: assert property (coreStart |-> acqSeen_q + 6'h01 == acqLen_q)
      else $error("acquisition length wrong");
   AST_DELAY_LEN: assert property (delayFire |-> dlySeen_q + 10'h001 == dlyLen_q)
      else $error("trigger delay length wrong");
   AST_FLAG_BLOCKS: assert property ($rose(busy) |-> !$past(doneFlag_q))
      else $error("conversion started with done flag set");
   AST_SW_START: assert property (
      swStart && !busy && !doneFlag_q |=> sampleEn && acqCnt_q == $past(acqLoad))
      else $error("software start not immediate");
   AST_EXT_IGNORED: assert property (
      trigEdge && busy && !trigPending |=> !trigPending)
      else $error("external trigger accepted while busy");
   AST_DIV_ONE: assert property (div_q == 2'h0 |-> adcTick)
      else $error("undivided converter clock missed a cycle");
   AST_IRQ: assert property ($rose(doneFlag_q) |-> adcIrq && $past(complete))
      else $error("flag rose without completion");

   COV_GATED_REPEAT: cover property (complete && ctrl2_q[`ADCC_C2_GATE] && !match);
   COV_BRAKE: cover property ($rose(pwmBrake));
   COV_DELAY_FIRE: cover property (delayFire && !doneFlag_q);
   COV_SW_DONE: cover property (swStart ##[1:200] $rose(doneFlag_q));

endmodule : adcc_top

`default_nettype wire

// ---- bench/adcc_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcc_core_model (
   input  wire logic        clock,      // system clock
   input  wire logic        resetn,     // async reset, low
   input  wire logic        coreStart,  // start pulse
   input  wire logic [11:0] value,      // result to deliver
   input  wire logic [3:0]  lat,        // conversion latency
   output logic             coreDone,   // done pulse
   output logic [11:0]      coreResult  // result, valid with done only
);
   logic [3:0] cnt_q;
   logic       busy_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         coreDone <= 1'b0;
         coreResult <= 12'h000;
      end else begin
         coreDone <= 1'b0;
         // not held outside the done cycle
         coreResult <= ~coreResult;
         if (coreStart) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
               busy_q <= 1'b0;
               coreDone <= 1'b1;
               coreResult <= value;
            end
         end
      end
   end
endmodule : adcc_core_model

`default_nettype wire

// ---- bench/test_adcc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"

module test_adcc_top;
   logic clock = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1, extTrigger = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000, value = 12'h000, coreResult;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, coreDone, coreStart, sampleEn;
   logic pwmBrake, pwm_run_bit, adcIrq, c;
   logic [15:0] tbl [5] = '{16'h0800, 16'h37ff, 16'hc7ff, 16'h8800, 16'hf000};
   int n_errors = 0, n_compared = 0, cyc = 0, acqN = 0, t0, t1;

   adcc_top dut_u (.clock, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'h1),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .extTrigger, .coreDone, .coreResult, .coreStart,
      .sampleEn, .pwmBrake, .pwm_run_bit, .adcIrq);
   adcc_core_model model_u (.clock, .resetn, .coreStart, .value, .lat(4'h3), .coreDone,
      .coreResult);

   always #4 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (sampleEn) acqN++;
      if (cyc == 30000) begin
         n_errors++;
         complete_run();
      end
   end

   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task wr(input logic [7:0] i, d);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge clock);
         a |= awready;
         w |= wready;
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do @(posedge clock); while (bvalid !== 1'b1);
   endtask : wr

   task rd(input logic [7:0] i);
      araddr <= {2'h0, i, 2'h0};
      arvalid <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      rv = rdata;
   endtask : rd

   task waitIrq;
      do @(posedge clock); while (adcIrq !== 1'b1);
   endtask : waitIrq

   task trg(input logic [8:0] n, output int t);
      wr(`ADCC_IDX_CTRL2, {7'h0, n[8]});
      wr(`ADCC_IDX_DLY, n[7:0]);
      extTrigger <= 1'b1;
      t = 0;
      do begin @(posedge clock); t++; end while (sampleEn !== 1'b1);
      extTrigger <= 1'b0;
      waitIrq();
      wr(`ADCC_IDX_CTRL0, 8'h00);
   endtask : trg

   task complete_run;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   initial begin
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(`ADCC_IDX_CTRL2);
      chk(rv, 32'h0);
      rd(8'h10);
      chk(rresp, 2'h2);
      wr(8'h10, 8'h00);
      chk(bresp, 2'h2);
      wr(`ADCC_IDX_THR_HI, 8'h80);
      foreach (tbl[k]) begin
         c = tbl[k][15] ? (tbl[k][11:0] < 12'h800) : (tbl[k][11:0] >= 12'h800);
         wr(`ADCC_IDX_CTRL2, {1'b0, tbl[k][15], 2'h0, tbl[k][14:12], 1'b0});
         value <= tbl[k][11:0];
         acqN = 0;
         wr(`ADCC_IDX_CTRL0, 8'h40);
         waitIrq();
         rd(`ADCC_IDX_CTRL2);
         chk(rv, {25'h0, tbl[k][15], 1'b0, c, tbl[k][14:12], 1'b0});
         chk(acqN, 4 * tbl[k][14:12] + 6);
         rd(`ADCC_IDX_RES_HI);
         chk(rv, {24'h0, tbl[k][11:4]});
         rd(`ADCC_IDX_CTRL0);
         chk(rv, 32'h80);
         wr(`ADCC_IDX_CTRL0, 8'h00);
      end
      wr(`ADCC_IDX_CTRL2, 8'h80);
      value <= 12'h900;
      wr(`ADCC_IDX_CTRL0, 8'h60);
      chk(pwm_run_bit, 1'b1);
      waitIrq();
      @(posedge clock);
      chk(pwmBrake, 1'b1);
      chk(pwm_run_bit, 1'b0);
      wr(`ADCC_IDX_CTRL0, 8'h20);
      chk(pwm_run_bit, 1'b1);
      wr(`ADCC_IDX_CTRL2, 8'h00);
      chk(pwmBrake, 1'b0);
      wr(`ADCC_IDX_CTRL2, 8'h20);
      value <= 12'h100;
      acqN = 0;
      wr(`ADCC_IDX_CTRL0, 8'h40);
      repeat (60) @(posedge clock);
      chk(adcIrq, 1'b0);
      chk(acqN > 12, 1'b1);
      rd(`ADCC_IDX_CTRL0);
      chk(rv, 32'h40);
      value <= 12'hc00;
      waitIrq();
      rd(`ADCC_IDX_RES_HI);
      chk(rv, 32'hc0);
      wr(`ADCC_IDX_CTRL0, 8'hc0);
      repeat (20) @(posedge clock);
      rd(`ADCC_IDX_CTRL0);
      chk(rv, 32'h80);
      wr(`ADCC_IDX_CTRL0, 8'h00);
      wr(`ADCC_IDX_CTRL1, 8'h02);
      trg(9'h000, t0);
      trg(9'h005, t1);
      chk(t1 - t0, 5);
      trg(9'h100, t1);
      chk(t1 - t0, 256);
      // trigger during a software conversion; a wrong arm would fire 256 ticks later
      acqN = 0;
      wr(`ADCC_IDX_CTRL0, 8'h40);
      extTrigger <= 1'b1;
      waitIrq();
      wr(`ADCC_IDX_CTRL0, 8'h00);
      repeat (300) @(posedge clock);
      chk(acqN, 6);
      extTrigger <= 1'b0;
      wr(`ADCC_IDX_CTRL1, 8'h30);
      acqN = 0;
      wr(`ADCC_IDX_CTRL0, 8'h40);
      waitIrq();
      chk(acqN >= 41 && acqN <= 48, 1'b1);
      complete_run();
   end
endmodule : test_adcc_top

`default_nettype wire
